//--- logic/aspc_map.svh
// field positions, codes, reset values and counts of the scan sequencer
`ifndef ASPC_MAP_SVH
`define ASPC_MAP_SVH
`define ASPC_FRAME_W 16
`define ASPC_FRAME_CNT_W 5
`define ASPC_SEL_BIT 15
`define ASPC_SCAN_HI 14
`define ASPC_SCAN_LO 11
`define ASPC_CHAN_HI 10
`define ASPC_CHAN_LO 7
`define ASPC_RST_HI 6
`define ASPC_RST_LO 5
`define ASPC_PM_HI 4
`define ASPC_PM_LO 3
`define ASPC_CHID_BIT 2
`define ASPC_SWTRIG_BIT 1
`define ASPC_CFG_HI 15
`define ASPC_CFG_LO 11
`define ASPC_CFG_CODE 5'h10
`define ASPC_REF_BIT 10
`define ASPC_AVG_BIT 9
`define ASPC_SPM_HI 1
`define ASPC_SPM_LO 0
`define ASPC_RST_FIFO 2'h1
`define ASPC_RST_ALL 2'h2
`define ASPC_SPM_FULL 2'h1
`define ASPC_SPM_PARTIAL 2'h2
`define ASPC_SCAN_RESET 4'h1
`define ASPC_CHAN_RESET 4'h0
`define ASPC_PM_RESET 2'h0
`define ASPC_REF_RESET 1'b0
`define ASPC_AVG_RESET 1'b0
`define ASPC_SPM_RESET 2'h0
`define ASPC_WAKE_CYCLES 2
`define ASPC_REP_STEP 5'h04
`endif

//--- logic/aspc_pkg.sv
// types shared by the scan sequencer and power control
package aspc_pkg;

    typedef enum logic [3:0] {
        ASPC_SCAN_KEEP = 4'h0,
        ASPC_SCAN_MANUAL = 4'h1,
        ASPC_SCAN_REPEAT = 4'h2,
        ASPC_SCAN_STD_INT = 4'h3,
        ASPC_SCAN_STD_EXT = 4'h4,
        ASPC_SCAN_UP_INT = 4'h5,
        ASPC_SCAN_UP_EXT = 4'h6,
        ASPC_SCAN_CUS_INT = 4'h7,
        ASPC_SCAN_CUS_EXT = 4'h8,
        ASPC_SCAN_USER_SEQ = 4'h9
    } aspc_scan_e;

    typedef enum logic [1:0] {
        ASPC_POL_NORMAL = 2'h0,
        ASPC_POL_AUTO_OFF = 2'h1,
        ASPC_POL_AUTO_BIAS = 2'h2,
        ASPC_POL_UNUSED = 2'h3
    } aspc_pol_e;

    typedef enum logic [3:0] {
        ASPC_ST_IDLE = 4'b0001,
        ASPC_ST_CONV = 4'b0010,
        ASPC_ST_SLEEP = 4'b0100,
        ASPC_ST_WAKE = 4'b1000
    } aspc_state_e;

    typedef struct packed {
        logic [3:0] channel;
        logic average;
    } aspc_conv_req_s;

endpackage : aspc_pkg

//--- logic/aspc_scan_power_ctrl.sv
// scan sequencer and power control behind the serial frame link
//
// Notes on behaviour
// - scan mode from bits 14:11, reset manual
// - channel field bits 10:7 gives N
// - power policy bits 4:3, reset normal
// - code zero keeps mode, still writes controls
// - manual: frame names channel, external clock
// - repeat: channel N 4/8/12/16 times
// - internal zero-to-N ascending, averaging allowed
// - external zero-to-N, one channel per frame
// - internal N-to-top ascending, averaging allowed
// - external N-to-top, one per frame
// - internal custom list ascending, averaging allowed
// - external custom list ascending, per frame
// - user sequence up to 256, external
// - codes above user sequence keep mode, still write controls
// - channel field is plain binary number
// - static shutdown: full or bias-only
// - external auto: sleep after frame, wake CS fall
// - internal auto: sleep after scan, wake trigger
// - policy: normal, full off, bias only, unused
// - two cycles after wake before converting
// - code 10000 selects the configuration word
// - config bit 10 chooses reference arrangement
// - config bit 9 averaging, internal only
`timescale 1ns/1ps
`include "aspc_map.svh"

module aspc_scan_power_ctrl #(
    parameter int NUM_CHANNELS = 16
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic din_i,
    input wire logic conversion_start_pin_n_i,
    input wire logic conv_done_i,
    input wire logic [NUM_CHANNELS-1:0] custom_list_i,
    input wire logic [3:0] seq_channel_i,
    input wire logic [7:0] seq_last_index_i,
    input wire logic [1:0] repeat_count_sel_i,
    output aspc_pkg::aspc_scan_e scan_mode_o,
    output logic [3:0] channel_number_o,
    output aspc_pkg::aspc_pol_e power_policy_o,
    output logic channel_id_enable_o,
    output logic software_trigger_o,
    output logic reference_choice_o,
    output logic averaging_enable_o,
    output logic [1:0] static_powerdown_bits_o,
    output logic conv_start_o,
    output aspc_pkg::aspc_conv_req_s conv_req_o,
    output logic [7:0] seq_index_o,
    output logic result_valid_o,
    output logic fifo_clear_o,
    output logic full_off_o,
    output logic bias_only_o,
    output logic frame_overrun_o
);

    // link pins pass two flip-flops; the third stage only keeps history
    logic sclk_s1, sclk_s2, sclk_s3;
    logic cs_s1, cs_s2, cs_s3;
    logic din_s1, din_s2;
    logic cnv_s1, cnv_s2, cnv_s3;

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
            {cs_s1, cs_s2, cs_s3} <= 3'h7;
            {din_s1, din_s2} <= 2'h0;
            {cnv_s1, cnv_s2, cnv_s3} <= 3'h7;
        end
        else
        begin
            {sclk_s1, sclk_s2, sclk_s3} <= {sclk_i, sclk_s1, sclk_s2};
            {cs_s1, cs_s2, cs_s3} <= {cs_n_i, cs_s1, cs_s2};
            {din_s1, din_s2} <= {din_i, din_s1};
            {cnv_s1, cnv_s2, cnv_s3} <=
                {conversion_start_pin_n_i, cnv_s1, cnv_s2};
        end
    end

    logic sclk_rise, cs_fall, cs_rise, cnv_fall;
    assign sclk_rise = sclk_s2 & ~sclk_s3;
    assign cs_fall = ~cs_s2 & cs_s3;
    assign cs_rise = cs_s2 & ~cs_s3;
    assign cnv_fall = ~cnv_s2 & cnv_s3;

    // frame shifter: msb first on rising serial clock while selected
    logic [`ASPC_FRAME_W-1:0] shift_reg;
    logic [`ASPC_FRAME_CNT_W-1:0] bit_cnt_reg;
    logic push;
    logic in_ready;

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            shift_reg <= 16'h0000;
            bit_cnt_reg <= 5'h00;
        end
        else if (cs_fall)
        begin
            bit_cnt_reg <= 5'h00;
        end
        else if (!cs_s2 && sclk_rise)
        begin
            shift_reg <= {shift_reg[`ASPC_FRAME_W-2:0], din_s2};
            if (bit_cnt_reg != 5'(`ASPC_FRAME_W))
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
    end

    // short frames are dropped; a full frame is offered at chip-select rise
    assign push = cs_rise && (bit_cnt_reg == 5'(`ASPC_FRAME_W));

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            frame_overrun_o <= 1'b0;
        else
            frame_overrun_o <= push & ~in_ready;
    end

    // two-entry frame buffer between the link and the decoder
    logic [`ASPC_FRAME_W-1:0] buf_mem [2];
    logic wr_ptr_reg, rd_ptr_reg;
    logic [1:0] buf_cnt_reg;
    logic out_valid, out_ready, take;
    logic [`ASPC_FRAME_W-1:0] w;

    assign in_ready = (buf_cnt_reg != 2'h2);
    assign out_valid = (buf_cnt_reg != 2'h0);
    assign take = out_valid & out_ready;
    assign w = buf_mem[rd_ptr_reg];

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            buf_mem[0] <= 16'h0000;
            buf_mem[1] <= 16'h0000;
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            buf_cnt_reg <= 2'h0;
        end
        else
        begin
            if (push && in_ready)
            begin
                buf_mem[wr_ptr_reg] <= shift_reg;
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (take)
                rd_ptr_reg <= ~rd_ptr_reg;
            buf_cnt_reg <= buf_cnt_reg + 2'(push & in_ready) - 2'(take);
        end
    end

    // frame decode
    logic is_mode, is_cfg, code_ok, rst_all;
    logic [3:0] code;
    logic [1:0] rst_field;

    assign is_mode = ~w[`ASPC_SEL_BIT];
    assign is_cfg = (w[`ASPC_CFG_HI:`ASPC_CFG_LO] == `ASPC_CFG_CODE);
    assign code = w[`ASPC_SCAN_HI:`ASPC_SCAN_LO];
    // zero and codes above the user sequence keep the mode
    assign code_ok = (code != 4'h0) &&
        (code <= aspc_pkg::ASPC_SCAN_USER_SEQ);
    assign rst_field = w[`ASPC_RST_HI:`ASPC_RST_LO];
    assign rst_all = is_mode && (rst_field == `ASPC_RST_ALL);

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            scan_mode_o <= aspc_pkg::aspc_scan_e'(`ASPC_SCAN_RESET);
            channel_number_o <= `ASPC_CHAN_RESET;
            power_policy_o <= aspc_pkg::aspc_pol_e'(`ASPC_PM_RESET);
            channel_id_enable_o <= 1'b0;
            reference_choice_o <= `ASPC_REF_RESET;
            averaging_enable_o <= `ASPC_AVG_RESET;
            static_powerdown_bits_o <= `ASPC_SPM_RESET;
        end
        else if (take && rst_all)
        begin
            scan_mode_o <= aspc_pkg::aspc_scan_e'(`ASPC_SCAN_RESET);
            channel_number_o <= `ASPC_CHAN_RESET;
            power_policy_o <= aspc_pkg::aspc_pol_e'(`ASPC_PM_RESET);
            channel_id_enable_o <= 1'b0;
            reference_choice_o <= `ASPC_REF_RESET;
            averaging_enable_o <= `ASPC_AVG_RESET;
            static_powerdown_bits_o <= `ASPC_SPM_RESET;
        end
        else if (take && is_mode)
        begin
            if (code_ok)
            begin
                scan_mode_o <= aspc_pkg::aspc_scan_e'(code);
                channel_number_o <= w[`ASPC_CHAN_HI:`ASPC_CHAN_LO];
            end
            power_policy_o <=
                aspc_pkg::aspc_pol_e'(w[`ASPC_PM_HI:`ASPC_PM_LO]);
            channel_id_enable_o <= w[`ASPC_CHID_BIT];
        end
        else if (take && is_cfg)
        begin
            reference_choice_o <= w[`ASPC_REF_BIT];
            averaging_enable_o <= w[`ASPC_AVG_BIT];
            static_powerdown_bits_o <= w[`ASPC_SPM_HI:`ASPC_SPM_LO];
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            fifo_clear_o <= 1'b0;
        else
            fifo_clear_o <= take && is_mode &&
                (rst_field == `ASPC_RST_FIFO || rst_field == `ASPC_RST_ALL);
    end

    // mode properties
    logic ext_mode, auto_pol, static_off;
    aspc_pkg::aspc_state_e state_reg;

    always_comb
    begin
        unique case (scan_mode_o)
            aspc_pkg::ASPC_SCAN_MANUAL,
            aspc_pkg::ASPC_SCAN_STD_EXT,
            aspc_pkg::ASPC_SCAN_UP_EXT,
            aspc_pkg::ASPC_SCAN_CUS_EXT,
            aspc_pkg::ASPC_SCAN_USER_SEQ: ext_mode = 1'b1;
            default: ext_mode = 1'b0;
        endcase
    end

    // policy three is unused and behaves as normal
    assign auto_pol = (power_policy_o == aspc_pkg::ASPC_POL_AUTO_OFF) ||
        (power_policy_o == aspc_pkg::ASPC_POL_AUTO_BIAS);
    assign static_off = (static_powerdown_bits_o != 2'h0);

    // channel set of the current mode, one bit per analog input
    logic [NUM_CHANNELS-1:0] scan_mask;

    for (genvar gi = 0; gi < NUM_CHANNELS; gi++)
    begin : g_mask
        always_comb
        begin
            case (scan_mode_o)
                aspc_pkg::ASPC_SCAN_STD_INT,
                aspc_pkg::ASPC_SCAN_STD_EXT:
                    scan_mask[gi] = (4'(gi) <= channel_number_o);
                aspc_pkg::ASPC_SCAN_UP_INT,
                aspc_pkg::ASPC_SCAN_UP_EXT:
                    scan_mask[gi] = (4'(gi) >= channel_number_o);
                aspc_pkg::ASPC_SCAN_CUS_INT,
                aspc_pkg::ASPC_SCAN_CUS_EXT:
                    scan_mask[gi] = custom_list_i[gi];
                default:
                    scan_mask[gi] = (4'(gi) == channel_number_o);
            endcase
        end
    end

    // lowest marked channel at or above start_at; bit 4 says found
    function automatic logic [4:0] aspc_find(
        input logic [NUM_CHANNELS-1:0] m,
        input logic [4:0] start_at
    );
        logic [4:0] r;
        r = 5'h00;
        for (int i = NUM_CHANNELS - 1; i >= 0; i--)
            if (m[i] && (5'(i) >= start_at))
                r = {1'b1, 4'(i)};
        return r;
    endfunction : aspc_find

    logic [4:0] pos_reg;
    logic [4:0] f_pos, f_zero, f_ext;
    assign f_pos = aspc_find(scan_mask, pos_reg);
    assign f_zero = aspc_find(scan_mask, 5'h00);
    assign f_ext = f_pos[4] ? f_pos : f_zero;

    // pending conversion requests
    logic pend_ext_reg, pend_int_reg, taken_reg;
    logic launch_ext, launch_int, int_done, int_scan_reg;
    logic idle_or_sleep;

    assign idle_or_sleep = (state_reg == aspc_pkg::ASPC_ST_IDLE) ||
        (state_reg == aspc_pkg::ASPC_ST_SLEEP);
    assign out_ready = idle_or_sleep & ~pend_ext_reg & ~pend_int_reg &
        ~taken_reg;
    assign launch_ext = (state_reg == aspc_pkg::ASPC_ST_IDLE) & pend_ext_reg;
    assign launch_int = (state_reg == aspc_pkg::ASPC_ST_IDLE) &
        pend_int_reg & ~pend_ext_reg;

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            software_trigger_o <= 1'b0;
        else if (take && is_mode && !rst_all && w[`ASPC_SWTRIG_BIT])
            software_trigger_o <= 1'b1;
        else if (int_done || (take && rst_all))
            software_trigger_o <= 1'b0;
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            taken_reg <= 1'b0;
            pend_ext_reg <= 1'b0;
            pend_int_reg <= 1'b0;
        end
        else
        begin
            taken_reg <= take;
            // each frame steps an external mode once, unless static shutdown is set
            if (taken_reg && ext_mode && !static_off)
                pend_ext_reg <= 1'b1;
            else if (launch_ext)
                pend_ext_reg <= 1'b0;
            if (!ext_mode && !static_off && idle_or_sleep &&
                ((taken_reg && software_trigger_o) || cnv_fall))
                pend_int_reg <= 1'b1;
            else if (launch_int || ext_mode || static_off)
                pend_int_reg <= 1'b0;
        end
    end

    // conversion and power state machine
    logic [4:0] rep_cnt_reg;
    logic [4:0] rep_limit;
    logic [1:0] wake_cnt_reg;
    logic more;
    logic avg_ok;

    assign rep_limit = 5'({repeat_count_sel_i, 2'h0}) + `ASPC_REP_STEP;
    assign more = (scan_mode_o == aspc_pkg::ASPC_SCAN_REPEAT) ?
        (rep_cnt_reg < rep_limit) : f_pos[4];
    assign int_done = (state_reg == aspc_pkg::ASPC_ST_CONV) & conv_done_i &
        int_scan_reg & ~more;
    assign avg_ok = averaging_enable_o & ~ext_mode;

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_reg <= aspc_pkg::ASPC_ST_IDLE;
            pos_reg <= 5'h00;
            rep_cnt_reg <= 5'h00;
            seq_index_o <= 8'h00;
            int_scan_reg <= 1'b0;
            wake_cnt_reg <= 2'h0;
            conv_start_o <= 1'b0;
            conv_req_o <= '0;
            result_valid_o <= 1'b0;
        end
        else
        begin
            conv_start_o <= 1'b0;
            result_valid_o <= 1'b0;
            if (take && is_mode && code_ok)
            begin
                pos_reg <= 5'h00;
                seq_index_o <= 8'h00;
            end
            unique case (state_reg)
                aspc_pkg::ASPC_ST_IDLE:
                begin
                    if (launch_ext)
                    begin
                        conv_start_o <= 1'b1;
                        conv_req_o.average <= 1'b0;
                        state_reg <= aspc_pkg::ASPC_ST_CONV;
                        int_scan_reg <= 1'b0;
                        if (scan_mode_o == aspc_pkg::ASPC_SCAN_MANUAL)
                            conv_req_o.channel <= channel_number_o;
                        else if (scan_mode_o ==
                            aspc_pkg::ASPC_SCAN_USER_SEQ)
                        begin
                            conv_req_o.channel <= seq_channel_i;
                            seq_index_o <= (seq_index_o == seq_last_index_i)
                                ? 8'h00 : seq_index_o + 8'h01;
                        end
                        else
                        begin
                            conv_req_o.channel <= f_ext[3:0];
                            pos_reg <= {1'b0, f_ext[3:0]} + 5'h01;
                        end
                    end
                    else if (launch_int && f_zero[4])
                    begin
                        conv_start_o <= 1'b1;
                        conv_req_o <= '{channel: f_zero[3:0], average: avg_ok};
                        pos_reg <= {1'b0, f_zero[3:0]} + 5'h01;
                        rep_cnt_reg <= 5'h01;
                        int_scan_reg <= 1'b1;
                        state_reg <= aspc_pkg::ASPC_ST_CONV;
                    end
                end
                aspc_pkg::ASPC_ST_CONV:
                begin
                    if (conv_done_i)
                    begin
                        result_valid_o <= 1'b1;
                        if (int_scan_reg && more)
                        begin
                            conv_start_o <= 1'b1;
                            if (scan_mode_o == aspc_pkg::ASPC_SCAN_REPEAT)
                                conv_req_o.channel <= channel_number_o;
                            else
                            begin
                                conv_req_o.channel <= f_pos[3:0];
                                pos_reg <= {1'b0, f_pos[3:0]} + 5'h01;
                            end
                            rep_cnt_reg <= rep_cnt_reg + 5'h01;
                        end
                        else
                        begin
                            int_scan_reg <= 1'b0;
                            state_reg <= auto_pol ? aspc_pkg::ASPC_ST_SLEEP
                                : aspc_pkg::ASPC_ST_IDLE;
                        end
                    end
                end
                aspc_pkg::ASPC_ST_SLEEP:
                begin
                    wake_cnt_reg <= 2'h0;
                    if ((ext_mode && cs_fall) || pend_ext_reg ||
                        pend_int_reg || !auto_pol)
                        state_reg <= aspc_pkg::ASPC_ST_WAKE;
                end
                aspc_pkg::ASPC_ST_WAKE:
                begin
                    wake_cnt_reg <= wake_cnt_reg + 2'h1;
                    if (wake_cnt_reg == 2'(`ASPC_WAKE_CYCLES - 1))
                        state_reg <= aspc_pkg::ASPC_ST_IDLE;
                end
            endcase
        end
    end

    // power outputs: static shutdown or the automatic sleep state
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            full_off_o <= 1'b0;
            bias_only_o <= 1'b0;
        end
        else
        begin
            full_off_o <= (static_powerdown_bits_o == `ASPC_SPM_FULL) ||
                (state_reg == aspc_pkg::ASPC_ST_SLEEP &&
                 power_policy_o == aspc_pkg::ASPC_POL_AUTO_OFF);
            bias_only_o <= (static_powerdown_bits_o == `ASPC_SPM_PARTIAL) ||
                (state_reg == aspc_pkg::ASPC_ST_SLEEP &&
                 power_policy_o == aspc_pkg::ASPC_POL_AUTO_BIAS);
        end
    end

endmodule : aspc_scan_power_ctrl

//--- verif/aspc_scan_power_ctrl_sva.sv
// concurrent checks on the scan sequencer ports
`timescale 1ns/1ps
module aspc_scan_power_ctrl_sva (
    input logic core_clk_i,
    input logic reset_n_i,
    input aspc_pkg::aspc_scan_e scan_mode_o,
    input logic [3:0] channel_number_o,
    input logic averaging_enable_o,
    input logic [1:0] static_powerdown_bits_o,
    input logic conv_start_o,
    input aspc_pkg::aspc_conv_req_s conv_req_o,
    input logic full_off_o,
    input logic bias_only_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    sequence s_launch;
        conv_start_o;
    endsequence
    sequence s_wake;
        $fell(full_off_o) || $fell(bias_only_o);
    endsequence
    property p_mode_legal;
        scan_mode_o inside {[4'h1:4'h9]};
    endproperty
    a_mode_legal: assert property (p_mode_legal)
        else $error("scan mode out of range");
    property p_single_chan;
        s_launch ##0 (scan_mode_o inside {aspc_pkg::ASPC_SCAN_MANUAL,
            aspc_pkg::ASPC_SCAN_REPEAT})
            |-> conv_req_o.channel == channel_number_o;
    endproperty
    a_single_chan: assert property (p_single_chan)
        else $error("single channel mode converts wrong channel");
    property p_lower;
        s_launch ##0 (scan_mode_o inside {aspc_pkg::ASPC_SCAN_STD_INT,
            aspc_pkg::ASPC_SCAN_STD_EXT})
            |-> conv_req_o.channel <= channel_number_o;
    endproperty
    a_lower: assert property (p_lower)
        else $error("channel above N in zero-to-N scan");
    property p_upper;
        s_launch ##0 (scan_mode_o inside {aspc_pkg::ASPC_SCAN_UP_INT,
            aspc_pkg::ASPC_SCAN_UP_EXT})
            |-> conv_req_o.channel >= channel_number_o;
    endproperty
    a_upper: assert property (p_upper)
        else $error("channel below N in N-to-top scan");
    property p_ext_no_avg;
        s_launch ##0 (scan_mode_o inside {4'h1, 4'h4, 4'h6, 4'h8, 4'h9})
            |-> !conv_req_o.average;
    endproperty
    a_ext_no_avg: assert property (p_ext_no_avg)
        else $error("averaging requested in external mode");
    property p_avg_gate;
        s_launch ##0 conv_req_o.average |-> averaging_enable_o;
    endproperty
    a_avg_gate: assert property (p_avg_gate)
        else $error("averaging without enable");
    property p_wake_gap;
        s_wake |-> !conv_start_o [*2];
    endproperty
    a_wake_gap: assert property (p_wake_gap)
        else $error("conversion inside wake interval");
    property p_static;
        $stable(static_powerdown_bits_o) [*2]
            ##0 (static_powerdown_bits_o inside {2'h1, 2'h2})
            |-> full_off_o == (static_powerdown_bits_o == 2'h1)
            && bias_only_o == (static_powerdown_bits_o == 2'h2)
            && !conv_start_o;
    endproperty
    a_static: assert property (p_static)
        else $error("static shutdown state wrong");
endmodule : aspc_scan_power_ctrl_sva

bind aspc_scan_power_ctrl aspc_scan_power_ctrl_sva i_aspc_scan_power_ctrl_sva (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .scan_mode_o(scan_mode_o),
    .channel_number_o(channel_number_o),
    .averaging_enable_o(averaging_enable_o),
    .static_powerdown_bits_o(static_powerdown_bits_o),
    .conv_start_o(conv_start_o),
    .conv_req_o(conv_req_o),
    .full_off_o(full_off_o),
    .bias_only_o(bias_only_o)
);

//--- verif/aspc_host_model.sv
// serial host that writes 16-bit frames over the link
`timescale 1ns/1ps
module aspc_host_model (
    output logic sclk_o,
    output logic cs_n_o,
    output logic din_o
);
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        din_o = 1'b0;
    end
    // msb first, data moved while the link clock is low; 160 ns period
    task automatic send(input logic [15:0] w);
        #7 cs_n_o = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            din_o = w[i];
            #80 sclk_o = 1'b1;
            #80 sclk_o = 1'b0;
        end
        #80 cs_n_o = 1'b1;
        // released data line shows the inverse of the last bit
        din_o = ~w[0];
        #400;
    endtask : send
endmodule : aspc_host_model

//--- verif/aspc_scan_power_ctrl_tb_top.sv
// self-checking bench of the scan sequencer and power control
`timescale 1ns/1ps
module aspc_scan_power_ctrl_tb_top;
    logic clk;
    logic rst_n = 1'b0;
    logic sclk, cs_n, din;
    logic cnv_n = 1'b1;
    logic done = 1'b0;
    logic [15:0] mask = 16'h8001;
    logic [3:0] seq_ch;
    logic [7:0] seq_last = 8'h00;
    logic [1:0] rep_sel = 2'h0;
    logic avg_on = 1'b0;
    aspc_pkg::aspc_scan_e mode;
    aspc_pkg::aspc_pol_e pol;
    aspc_pkg::aspc_conv_req_s req;
    logic [3:0] chan;
    logic [7:0] sidx;
    logic swt, ref_o, avg, start, pwr_off, bias, chid, rv;
    logic [1:0] static_powerdown_bits;
    int n_errors = 0, n_checks = 0;
    int cyc = 0, dly = 0, nres = 0;
    logic [3:0] seen[$], want[$];

    aspc_host_model i_aspc_host_model (.sclk_o(sclk), .cs_n_o(cs_n),
        .din_o(din));
    aspc_scan_power_ctrl i_aspc_scan_power_ctrl (.core_clk_i(clk),
        .reset_n_i(rst_n), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
        .conversion_start_pin_n_i(cnv_n), .conv_done_i(done),
        .custom_list_i(mask), .seq_channel_i(seq_ch),
        .seq_last_index_i(seq_last), .repeat_count_sel_i(rep_sel),
        .scan_mode_o(mode), .channel_number_o(chan), .power_policy_o(pol),
        .channel_id_enable_o(chid), .software_trigger_o(swt),
        .reference_choice_o(ref_o), .averaging_enable_o(avg),
        .static_powerdown_bits_o(static_powerdown_bits), .conv_start_o(start),
        .conv_req_o(req), .seq_index_o(sidx), .result_valid_o(rv),
        .fifo_clear_o(), .full_off_o(pwr_off), .bias_only_o(bias),
        .frame_overrun_o());

    // sequence entries hold channel index xor 5
    assign seq_ch = sidx[3:0] ^ 4'h5;
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // converter core answers each start three cycles later
    always @(posedge clk)
    begin
        done <= (dly == 1);
        dly <= (start === 1'b1) ? 3 : (dly > 0) ? dly - 1 : 0;
        if (start === 1'b1)
            seen.push_back(req.channel);
        if (rv === 1'b1)
            nres++;
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            n_errors++;
            test_done();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    function automatic logic [15:0] mw(input logic [3:0] sc,
        input logic [3:0] n, input logic [1:0] pm, input logic sw);
        return {1'b0, sc, n, 2'h0, pm, sw, sw, 1'b0};
    endfunction : mw

    function automatic bit in_scan(input logic [3:0] sc, input logic [3:0] n,
        input int k);
        case (sc)
            4'h1: return k == 0;
            4'h2: return k < 4 * rep_sel + 4;
            4'h3, 4'h4: return k <= n;
            4'h5, 4'h6: return k >= n && k < 16;
            4'h7, 4'h8: return k < 16 && mask[k] === 1'b1;
            default: return k <= seq_last;
        endcase
    endfunction : in_scan

    task automatic send(input logic [15:0] w);
        i_aspc_host_model.send(w);
        repeat (12) @(posedge clk);
    endtask : send

    task automatic cmp_list(input bit ext, input logic [1:0] pm);
        for (int i = 0; i < 600 && seen.size() < want.size(); i++)
            @(posedge clk);
        repeat (12) @(posedge clk);
        chk(seen.size(), want.size());
        chk(nres, seen.size());
        foreach (want[k])
            chk(seen[k], want[k]);
        chk(req.average, !ext && avg_on);
        chk({pwr_off, bias, swt}, {pm == 1, pm == 2, 1'b0});
    endtask : cmp_list

    task automatic run(input logic [3:0] sc, input logic [3:0] n,
        input logic [1:0] pm);
        bit ext = sc inside {4'h1, 4'h4, 4'h6, 4'h8, 4'h9};
        want = {};
        for (int k = 0; k < 256; k++)
            if (in_scan(sc, n, k))
                want.push_back(sc == 4'h2 ? n : sc == 4'h9 ? 4'(k) ^ 4'h5
                    : sc == 4'h1 ? n : 4'(k));
        seen = {};
        nres = 0;
        send(mw(sc, n, pm, !ext));
        chk({mode, chan, chid}, {sc, n, !ext});
        for (int k = 1; ext && k < want.size(); k++)
            send(mw(4'h0, 4'h0, pm, 1'b0));
        cmp_list(ext, pm);
    endtask : run

    initial
    begin
        void'($urandom(79));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk(mode, 16'h0001);
        chk({chan, pol, ref_o, avg, static_powerdown_bits}, 16'h0000);
        avg_on = 1'($urandom_range(1));
        send({5'h10, 1'b1, avg_on, 9'h000});
        chk({ref_o, avg, mode}, {1'b1, avg_on, 4'h1});
        @(posedge clk);
        mask <= 16'($urandom()) | 16'h8001;
        seq_last <= 8'($urandom_range(7));
        rep_sel <= 2'($urandom_range(3));
        for (int m = 1; m < 10; m++)
            run(4'(m), 4'($urandom_range(15)), 2'(m % 3));
        run(4'h5, 4'hF, 2'h1);
        seen = {};
        nres = 0;
        cnv_n <= 1'b0;
        repeat (4) @(posedge clk);
        cnv_n <= 1'b1;
        cmp_list(1'b0, 2'h1);
        send(mw(4'h0, 4'h3, 2'h3, 1'b0));
        chk({mode, chan, pol}, {4'h5, 4'hF, 2'h3});
        for (int c = 10; c < 16; c++)
        begin
            send(mw(4'(c), 4'h3, 2'h0, 1'b0));
            chk({mode, chan}, {4'h5, 4'hF});
        end
        for (int s = 1; s < 3; s++)
        begin
            send({5'h10, 9'h000, 2'(s)});
            chk({pwr_off, bias}, {s == 1, s == 2});
        end
        test_done();
    end
endmodule : aspc_scan_power_ctrl_tb_top
